// file: hw/reset_src_defines.svh
// Constants of the reset-source block
`ifndef RESET_SRC_DEFINES_SVH
`define RESET_SRC_DEFINES_SVH
`define SERVICE_ADDR 16'hFFFF
`define PRESC_W 12
`define PRESC_TICK 12'hFF0
`define PRESC_CLR_HI 11
`define PRESC_CLR_LO 4
`define BUSDIV_W 2
`define BUSDIV_LAST 2'h3
`define BUSDIV_ZERO 2'h0
`define OSC2_PERIOD_PS 5000
`define BUS_PERIOD_PS 20000
`define BUS_DIV (`BUS_PERIOD_PS / `OSC2_PERIOD_PS)
`endif

// file: hw/reset_src_pkg.sv
// Types shared by the reset-source block
package reset_src_pkg;
  typedef struct packed {
    logic [15:0] addr;    // Address of the current access
    logic wr;             // Write strobe
    logic rd;             // Read strobe
    logic fetch;          // Access is an opcode fetch
    logic mapped;         // Address hits a mapped location
    logic illegal_op;     // Decoder saw an illegal instruction
    logic stop_op;        // Decoder saw the stop instruction
  } cpu_req_t;
  typedef struct packed {
    logic power_on;
    logic watchdog;
    logic bad_opcode_flag;
    logic bad_address_flag;
  } reset_cause_t;
  typedef enum logic [0:0] {
    RUN_S = 1'b0,
    HOLD_S = 1'b1
  } rst_state_t;
endpackage : reset_src_pkg

// file: hw/system_reset_source_logic.sv
// Watchdog, bad opcode and bad address reset sources with break protection
`timescale 1ns/1ps
`include "reset_src_defines.svh"
module system_reset_source_logic
  import reset_src_pkg::*;
#(
  parameter int WDOG_W = 6,
  parameter int HOLD_W = 5,
  parameter logic [HOLD_W-1:0] HOLD_CYC = 5'h1F,
  parameter int FLAG_N = 4
)(
  input wire logic i_ref_clk,                   // Doubled oscillator clock
  input wire logic i_rst_n,                     // Sync reset, active low
  input wire logic i_power_on_reset_in,         // Pulse from power-on module
  input wire cpu_req_t i_cpu,                   // CPU access and decode
  input wire logic i_stop_enable,               // Option bit, stop allowed
  input wire logic i_monitor_mode,              // Monitor mode active
  input wire logic i_rst_pin_hv,                // Reset pin at high voltage
  input wire logic i_first_interrupt_pin_hv,    // First interrupt pin high V
  input wire logic i_break_state,               // Device in break state
  input wire logic i_break_clear_enable,        // Allow flag clear in break
  input wire logic [FLAG_N-1:0] i_flag_set,     // Module flag set events
  input wire logic [FLAG_N-1:0] i_flag_arm,     // First clear step
  input wire logic [FLAG_N-1:0] i_flag_clr,     // Final clear step
  output logic o_bus_clk_en,                    // Bus clock enable pulse
  output logic o_internal_reset,                // Internal reset level
  output logic o_rst_pin_out,                   // Reset pin drive value
  output logic o_rst_pin_oe,                    // Reset pin output enable
  output reset_cause_t o_reset_cause_register,  // Reset cause flags
  output logic [WDOG_W-1:0] o_wdog_count,       // Watchdog counter
  output logic [FLAG_N-1:0] o_module_flags      // Protected module flags
);

  logic [`BUSDIV_W-1:0] div_q;
  logic bus_en_q;
  logic [`PRESC_W-1:0] presc_q;
  logic [WDOG_W-1:0] wdog_q;
  logic [1:0] hv_meta_q;
  logic [1:0] hv_q;
  rst_state_t state_q;
  logic [HOLD_W-1:0] hold_q;
  reset_cause_t cause_q;
  logic pin_out_q;
  logic [FLAG_N-1:0] flags_q;
  logic [FLAG_N-1:0] armed_q;
  logic service;
  logic presc_tick;
  logic wdog_off;
  logic wdog_ev;
  logic opc_ev;
  logic adr_ev;
  logic any_ev;
  logic clr_allow;

  // Decode of the watchdog service write
  function automatic logic is_service(input cpu_req_t req);
    return req.wr && (req.addr == `SERVICE_ADDR);
  endfunction : is_service

  // Bus clock divider, one enable every fourth fast cycle
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      div_q <= `BUSDIV_ZERO;
      bus_en_q <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      bus_en_q <= (div_q == `BUSDIV_LAST);
    end
  end

  // High voltage pin sensing, two-stage synchroniser
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      hv_meta_q <= 2'h0;
      hv_q <= 2'h0;
    end
    else
    begin
      hv_meta_q <= {i_first_interrupt_pin_hv, i_rst_pin_hv};
      hv_q <= hv_meta_q;
    end
  end

  // Source events, all combinational; only the pin high voltage levels come through the synchroniser
  assign service = is_service(i_cpu);
  assign presc_tick = (presc_q == `PRESC_TICK);
  assign wdog_off = (i_monitor_mode && (hv_q[0] || hv_q[1]))
                 || (i_break_state && hv_q[0]);
  assign wdog_ev = presc_tick && !wdog_off && (&wdog_q)
                && !service;
  assign opc_ev = i_cpu.illegal_op
               || (i_cpu.stop_op && !i_stop_enable);
  assign adr_ev = i_cpu.fetch && !i_cpu.mapped;
  assign any_ev = (wdog_ev || opc_ev || adr_ev) && (state_q == RUN_S);
  assign clr_allow = !i_break_state || i_break_clear_enable;

  // Prescaler, partly cleared by the service write
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || state_q == HOLD_S)
      presc_q <= '0;
    else if (service)
    begin
      presc_q[`PRESC_CLR_HI:`PRESC_CLR_LO] <= '0;
      presc_q[`PRESC_CLR_LO-1:0] <= presc_q[`PRESC_CLR_LO-1:0] + 4'h1;
    end
    else
      presc_q <= presc_q + 12'h001;
  end

  // Watchdog counter, advanced by the prescaler tick
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || state_q == HOLD_S || service || wdog_off)
      wdog_q <= '0;
    else if (presc_tick)
      wdog_q <= wdog_q + WDOG_W'(1);
  end

  // Internal reset sequencer, holds the pin low for a fixed time
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= RUN_S;
      hold_q <= '0;
    end
    else
    begin
      unique case (state_q)
        RUN_S:
        begin
          if (any_ev)
          begin
            state_q <= HOLD_S;
            hold_q <= HOLD_CYC;
          end
        end
        HOLD_S:
        begin
          if (hold_q == '0)
            state_q <= RUN_S;
          else
            hold_q <= hold_q - HOLD_W'(1);
        end
      endcase
    end
  end

  // Reset cause flags, replaced by each new cause
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      cause_q <= '0;
    else if (i_power_on_reset_in)
      cause_q <= '{power_on: 1'b1, default: 1'b0};
    else if (any_ev)
    begin
      cause_q.power_on <= 1'b0;
      cause_q.watchdog <= wdog_ev;
      cause_q.bad_opcode_flag <= opc_ev;
      cause_q.bad_address_flag <= adr_ev;
    end
  end

  // Pin drive level is always low when enabled
  always_ff @(posedge i_ref_clk)
  begin
    pin_out_q <= 1'b0;
  end

  // Break-protected module flags, set wins over clear
  genvar g;
  generate
    for (g = 0; g < FLAG_N; g++)
    begin : g_flag
      always_ff @(posedge i_ref_clk)
      begin
        if (!i_rst_n)
        begin
          flags_q[g] <= 1'b0;
          armed_q[g] <= 1'b0;
        end
        else
        begin
          if (i_flag_set[g])
          begin
            flags_q[g] <= 1'b1;
            armed_q[g] <= 1'b0;
          end
          else if (clr_allow && i_flag_clr[g] &&
                   (armed_q[g] || i_flag_arm[g]))
          begin
            flags_q[g] <= 1'b0;
            armed_q[g] <= 1'b0;
          end
          else if (clr_allow && i_flag_arm[g] && flags_q[g])
            armed_q[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // Output connections, all from flip-flops
  assign o_bus_clk_en = bus_en_q;
  assign o_internal_reset = (state_q == HOLD_S);
  assign o_rst_pin_out = pin_out_q;
  assign o_rst_pin_oe = (state_q == HOLD_S);
  assign o_reset_cause_register = cause_q;
  assign o_wdog_count = wdog_q;
  assign o_module_flags = flags_q;

  // Checks on the reset sources, bus divider and protected flags
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  wdog_reset_a: assert property (wdog_ev && state_q == RUN_S
    && !i_power_on_reset_in |=> o_internal_reset && cause_q.watchdog)
    else $error("watchdog overflow gave no reset");

  pin_drive_a: assert property (any_ev |=>
    o_rst_pin_oe && !o_rst_pin_out ##1 o_rst_pin_oe)
    else $error("reset pin not driven low");

  service_clr_a: assert property (service && state_q == RUN_S
    |=> wdog_q == '0 && presc_q[`PRESC_CLR_HI:`PRESC_CLR_LO] == '0)
    else $error("service write did not clear counters");

  presc_tick_a: assert property (presc_tick && !service
    |=> presc_q == $past(presc_q) + 12'h001 || state_q == HOLD_S)
    else $error("prescaler did not advance past tick");

  wdog_off_a: assert property (wdog_off |=> wdog_q == '0)
    else $error("watchdog counted while disabled");

  brk_wdog_a: assert property (i_break_state && hv_q[0]
    && state_q == RUN_S |=> wdog_q == '0)
    else $error("watchdog counted in break with high voltage");

  bad_opc_a: assert property (i_cpu.stop_op && !i_stop_enable
    && state_q == RUN_S && !i_power_on_reset_in
    |=> o_internal_reset && cause_q.bad_opcode_flag)
    else $error("disabled stop did not reset");

  bad_instr_a: assert property (i_cpu.illegal_op && state_q == RUN_S
    && !i_power_on_reset_in |=> o_internal_reset && cause_q.bad_opcode_flag)
    else $error("illegal instruction did not reset");

  bad_adr_a: assert property (adr_ev && state_q == RUN_S
    && !i_power_on_reset_in |=> cause_q.bad_address_flag)
    else $error("unmapped fetch did not set flag");

  data_ok_a: assert property ((i_cpu.rd || i_cpu.wr)
    && !i_cpu.fetch && !opc_ev && !wdog_ev && state_q == RUN_S
    |=> !o_internal_reset)
    else $error("data access caused a reset");

  bus_div_a: assert property (bus_en_q |=>
    !bus_en_q [*3] ##1 bus_en_q)
    else $error("bus enable not every fourth cycle");

  brk_hold_a: assert property (i_break_state
    && !i_break_clear_enable |=> ($past(flags_q) & ~flags_q) == '0)
    else $error("flag cleared in protected break");

  brk_clr_a: assert property (i_break_state && i_break_clear_enable
    && flags_q[0] && i_flag_arm[0] && i_flag_clr[0] && !i_flag_set[0]
    |=> !flags_q[0])
    else $error("enabled break clear did not clear");

  two_step_a: assert property (armed_q[0] && !i_flag_set[0]
    && !i_break_state && i_flag_clr[0] |=> !flags_q[0])
    else $error("second step did not clear armed flag");

  cause_ro_a: assert property (!any_ev && !i_power_on_reset_in
    |=> $stable(cause_q))
    else $error("cause flags changed without a cause");

  wdog_rst_c: cover property (wdog_ev ##1 o_internal_reset);
  opc_rst_c: cover property (opc_ev && state_q == RUN_S);
  adr_rst_c: cover property (adr_ev && state_q == RUN_S);
  brk_clr_c: cover property (i_break_state && i_break_clear_enable
    && $fell(flags_q[0]));

endmodule : system_reset_source_logic

// file: dv/cpu_access_model.sv
// CPU-side model presenting accesses and decode events
`timescale 1ns/1ps
module cpu_access_model
  import reset_src_pkg::*;
(
  input wire logic i_ref_clk, // Doubled oscillator clock
  output cpu_req_t o_cpu      // Access toward the block
);
  initial o_cpu = '0;
  // One-cycle access, then controls drop and the address turns over
  task automatic access(input logic [15:0] addr, input logic [5:0] kind);
    @(posedge i_ref_clk);
    o_cpu <= {addr, kind};
    @(posedge i_ref_clk);
    o_cpu <= {~addr, 6'h00};
  endtask : access
  // Watchdog service write, one write access to address 16'hFFFF
  task automatic service();
    access(16'hFFFF, 6'h20);
  endtask : service
endmodule : cpu_access_model

// file: dv/test_system_reset_source_logic.sv
// Self-checking bench for the reset-source block
`timescale 1ns/1ps
module test_system_reset_source_logic
  import reset_src_pkg::*;
;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_power_on_reset_in = 1'b0;
  logic i_stop_enable = 1'b1;
  logic i_monitor_mode = 1'b0;
  logic i_rst_pin_hv = 1'b0;
  logic i_first_interrupt_pin_hv = 1'b0;
  logic i_break_state = 1'b0;
  logic i_break_clear_enable = 1'b0;
  logic [3:0] i_flag_set = 4'h0;
  logic [3:0] i_flag_arm = 4'h0;
  logic [3:0] i_flag_clr = 4'h0;
  cpu_req_t i_cpu;
  logic o_bus_clk_en, o_internal_reset, o_rst_pin_out, o_rst_pin_oe;
  reset_cause_t o_reset_cause_register;
  logic [1:0] o_wdog_count;
  logic [3:0] o_module_flags;
  logic [3:0] exp_q[$];
  logic [5:0] kinds [4] = '{6'h08, 6'h0E, 6'h0D, 6'h0A};
  logic [3:0] causes [4] = '{4'h1, 4'h2, 4'h2, 4'h3};
  logic [15:0] a;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  // 200 MHz clock
  always #2.5 i_ref_clk = ~i_ref_clk;
  system_reset_source_logic #(.WDOG_W(2)) i_system_reset_source_logic (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_power_on_reset_in(i_power_on_reset_in), .i_cpu(i_cpu),
    .i_stop_enable(i_stop_enable), .i_monitor_mode(i_monitor_mode),
    .i_rst_pin_hv(i_rst_pin_hv),
    .i_first_interrupt_pin_hv(i_first_interrupt_pin_hv),
    .i_break_state(i_break_state),
    .i_break_clear_enable(i_break_clear_enable),
    .i_flag_set(i_flag_set), .i_flag_arm(i_flag_arm),
    .i_flag_clr(i_flag_clr), .o_bus_clk_en(o_bus_clk_en),
    .o_internal_reset(o_internal_reset), .o_rst_pin_out(o_rst_pin_out),
    .o_rst_pin_oe(o_rst_pin_oe),
    .o_reset_cause_register(o_reset_cause_register),
    .o_wdog_count(o_wdog_count), .o_module_flags(o_module_flags));
  cpu_access_model i_cpu_access_model (.i_ref_clk(i_ref_clk), .o_cpu(i_cpu));
  // Compare seen and expected values
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // Print counts and verdict, then stop
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // Wait for a reset hold to start, then count its length
  task automatic wait_hold(input int lim, output int len);
    len = 0;
    for (int k = 0; k < lim && o_internal_reset !== 1'b1; k++)
      @(negedge i_ref_clk);
    while (o_internal_reset === 1'b1 && len < 100)
    begin
      @(negedge i_ref_clk);
      len++;
    end
  endtask : wait_hold
  // Each reset start takes the oldest noted cause
  always @(posedge o_internal_reset)
  begin
    #1;
    if (exp_q.size() == 0)
      check(8'h01, 8'h00);
    else
      check({4'h0, o_reset_cause_register},
        {4'h0, exp_q.pop_front()});
    check({6'h00, o_rst_pin_oe, o_rst_pin_out}, 8'h02);
  end
  // Cycle ceiling against a hung run
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fails++;
      end_of_test();
    end
  end
  // Main sequence
  initial
  begin
    n = $urandom(49);
    repeat (2) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    n = 0;
    repeat (40)
    begin
      @(negedge i_ref_clk);
      n += o_bus_clk_en;
    end
    // First pulse at the fourth edge after release, then every fourth
    check(n[7:0], 8'h09);
    $display("bus clock test done");
    @(posedge i_ref_clk);
    i_stop_enable <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      exp_q.push_back(causes[i]);
      a = 16'($urandom());
      i_cpu_access_model.access(a, kinds[i]);
      wait_hold(8, n);
      check(n[7:0], 8'h20);
    end
    $display("reset source test done");
    @(posedge i_ref_clk);
    i_stop_enable <= 1'b1;
    a = 16'($urandom());
    a[0] = 1'b0;
    i_cpu_access_model.access(a, 6'h0D);
    i_cpu_access_model.access(a, 6'h10);
    i_cpu_access_model.access(a, 6'h20);
    repeat (4) @(negedge i_ref_clk);
    check({7'h00, o_internal_reset}, 8'h00);
    $display("quiet access test done");
    n = 0;
    while (o_wdog_count === 2'h0 && n < 9000)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    check({6'h00, o_wdog_count}, 8'h01);
    i_cpu_access_model.service();
    repeat (2) @(negedge i_ref_clk);
    check({6'h00, o_wdog_count}, 8'h00);
    exp_q.push_back(4'h4);
    wait_hold(20000, n);
    check(n[7:0], 8'h20);
    $display("watchdog test done");
    @(posedge i_ref_clk);
    i_monitor_mode <= 1'b1;
    n = $urandom();
    i_rst_pin_hv <= n[0];
    i_first_interrupt_pin_hv <= ~n[0];
    // Long enough for two ticks, so a live counter would be nonzero
    repeat (9000) @(negedge i_ref_clk);
    check({6'h00, o_wdog_count}, 8'h00);
    @(posedge i_ref_clk);
    i_monitor_mode <= 1'b0;
    i_first_interrupt_pin_hv <= 1'b0;
    i_rst_pin_hv <= 1'b1;
    i_break_state <= 1'b1;
    repeat (9000) @(negedge i_ref_clk);
    check({6'h00, o_wdog_count}, 8'h00);
    $display("watchdog disable test done");
    @(posedge i_ref_clk);
    i_break_state <= 1'b0;
    i_rst_pin_hv <= 1'b0;
    i_flag_set <= 4'h3;
    @(posedge i_ref_clk);
    i_flag_set <= 4'h0;
    i_flag_arm <= 4'h2;
    @(posedge i_ref_clk);
    i_flag_arm <= 4'h0;
    i_break_state <= 1'b1;
    @(posedge i_ref_clk);
    i_flag_arm <= 4'h3;
    i_flag_clr <= 4'h3;
    @(posedge i_ref_clk);
    i_flag_arm <= 4'h0;
    i_flag_clr <= 4'h0;
    repeat (2) @(negedge i_ref_clk);
    check({4'h0, o_module_flags}, 8'h03);
    @(posedge i_ref_clk);
    i_break_state <= 1'b0;
    i_flag_clr <= 4'h2;
    @(posedge i_ref_clk);
    i_flag_clr <= 4'h0;
    i_break_clear_enable <= 1'b1;
    i_break_state <= 1'b1;
    @(posedge i_ref_clk);
    i_flag_arm <= 4'h1;
    i_flag_clr <= 4'h1;
    @(posedge i_ref_clk);
    i_flag_arm <= 4'h0;
    i_flag_clr <= 4'h0;
    i_break_state <= 1'b0;
    repeat (3) @(negedge i_ref_clk);
    check({4'h0, o_module_flags}, 8'h00);
    $display("break flag test done");
    // Power-on pulse leaves only the power-on cause, no internal reset
    @(posedge i_ref_clk);
    i_power_on_reset_in <= 1'b1;
    @(posedge i_ref_clk);
    i_power_on_reset_in <= 1'b0;
    @(negedge i_ref_clk);
    check({3'h0, o_internal_reset, o_reset_cause_register}, 8'h08);
    $display("power-on cause test done");
    end_of_test();
  end
endmodule : test_system_reset_source_logic
